// ---- pmon_sequencer.sv ----
// power monitor sampling sequencer with peak aux tracking and alert gating.
// assumes a command port already decoded from the serial bus, a converter
// front end on core_clk, and fault flags produced by status logic on core_clk.
`timescale 1ns/1ns

// Overview of operation
// - peak aux register holds largest aux result in bits 11:0, 15:12 read zero
// - writing zero to peak aux register clears the stored peak
// - run bit resets to one; one samples, zero stops the monitor
// - single-shot mode clears run bit after one complete sampling cycle
// - continuous mode keeps sampling until host writes run bit to zero
// - run control bits 7:1 always read zero
// - config bit 7 picks single-shot (0) or continuous (1), resets continuous
// - config bit 6 adds the aux channel, resets to zero
// - config bits 4:3 pick sense range 25 mV or 50 mV, variant reset
// - config bits 2:0 pick averaging 1 to 128 samples, reset 111
// - sampling config resets to 0x8F with range reset 01, 0x97 with range reset 10
// - alert enable register resets to 0x8000, switch health alert on
// - bit 14 lets the overcurrent fault flag raise the alert
// - bit 13 lets the input overvoltage fault flag raise the alert
// - output function field 00 makes general output one the alert pin
module pmon_sequencer
    import pmon_pkg::*;
#(
    parameter logic [1:0] RANGE_RESET = 2'b01,
    parameter int         DATA_W      = 12
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // register command port
    input  wire logic [7:0]        reg_cmd,
    input  wire logic              reg_wr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    output logic                   reg_rack,
    output logic                   reg_unknown,
    // converter front end
    output logic                   conv_start,
    output logic      [1:0]        conv_channel,
    input  wire logic              conv_done,
    input  wire logic [DATA_W-1:0] conv_result,
    output logic      [1:0]        current_sense_range,
    // averaged results
    output logic      [DATA_W-1:0] vin_avg,
    output logic      [DATA_W-1:0] output_current_avg,
    output logic                   results_valid,
    // fault flags and alert pin
    input  wire logic              switch_health_bad_flag,
    input  wire logic              overcurrent_fault_flag,
    input  wire logic              input_overvoltage_fault_flag,
    output logic                   alert,
    output logic                   general_output_one_o,
    output logic                   general_output_one_oe
);
    // range field of the reset value follows the product variant
    localparam logic [7:0] CFG_RESET =
        (SAMPLE_CFG_RESET & ~CFG_RANGE_MASK) | {3'b000, RANGE_RESET, 3'b000};

    if (RANGE_RESET == RANGE_RSVD_LO || RANGE_RESET == RANGE_RSVD_HI
        || DATA_W != PEAK_W) begin : g_bad_params
        $error("pmon_sequencer needs a valid range reset and 12-bit data");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    seq_state_e        state_reg,    state_next;
    adc_chan_e         chan_reg,     chan_next;
    logic [7:0]        round_reg,    round_next;
    logic [2:0]        avg_log_reg,  avg_log_next;
    logic              aux_on_reg,   aux_on_next;
    logic              run_reg,      run_next;
    logic [7:0]        cfg_reg,      cfg_next;
    logic [15:0]       alert_en_reg, alert_en_next;
    logic [PEAK_W-1:0] peak_reg,     peak_next;
    logic [15:0]       rdata_reg,    rdata_next;
    logic              rack_reg,     unknown_reg,  unknown_next;
    logic              alert_reg,    alert_next;

    logic              wr_run;
    logic              wr_cfg;
    logic              wr_alert;
    logic              peak_clear;
    logic              sample_done;
    logic              aux_valid;
    logic [7:0]        round_last;
    logic [PEAK_W-1:0] peak_base;

    avg_link_if #(.DATA_W(DATA_W)) vin_link ();
    avg_link_if #(.DATA_W(DATA_W)) output_current_link ();

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign wr_run      = reg_wr && (reg_cmd == CMD_RUN_CTRL);
    assign wr_cfg      = reg_wr && (reg_cmd == CMD_SAMPLE_CFG);
    assign wr_alert    = reg_wr && (reg_cmd == CMD_ALERT_EN);
    assign peak_clear  = reg_wr && (reg_cmd == CMD_PEAK_AUX) && (reg_wdata == PEAK_CLEAR_VALUE);
    assign sample_done = (state_reg == SEQ_WAIT) && conv_done;
    assign aux_valid   = sample_done && (chan_reg == CH_AUX);
    assign round_last  = 8'((9'd1 << avg_log_reg) - 9'd1);

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        cfg_next      = cfg_reg;
        alert_en_next = alert_en_reg;
        // mode, aux, range and averaging stored as written
        if (wr_cfg) begin
            cfg_next = reg_wdata[7:0] & ~CFG_RSVD_MASK;
        end
        if (wr_alert) begin
            alert_en_next = reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // run bit and peak tracking
    // ------------------------------------------------------------------
    always_comb begin
        run_next = run_reg;
        if (state_reg == SEQ_DONE && !cfg_reg[MODE_BIT]) begin
            run_next = 1'b0;
        end
        // host write comes last so a restart in the same cycle wins
        if (wr_run) begin
            run_next = reg_wdata[RUN_BIT];
        end
        // only a greater result replaces the peak; a result racing a clear is kept
        peak_base = peak_clear ? PEAK_RESET : peak_reg;
        peak_next = peak_base;
        if (aux_valid && (conv_result > peak_base)) begin
            peak_next = conv_result;
        end
    end

    // ------------------------------------------------------------------
    // sampling sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        chan_next    = chan_reg;
        round_next   = round_reg;
        avg_log_next = avg_log_reg;
        aux_on_next  = aux_on_reg;
        case (state_reg)
            SEQ_IDLE: begin
                // averaging and aux are latched so a mid-cycle write cannot split a cycle; range is not
                if (run_reg) begin
                    state_next   = SEQ_REQ;
                    chan_next    = CH_VIN;
                    round_next   = 8'h00;
                    avg_log_next = cfg_reg[AVG_LSB +: AVG_W];
                    aux_on_next  = cfg_reg[AUX_BIT];
                end
            end
            SEQ_REQ: begin
                state_next = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (conv_done) begin
                    state_next = SEQ_REQ;
                    // aux joins the round only when enabled
                    if (chan_reg == CH_VIN) begin
                        chan_next = CH_OUTPUT_CURRENT;
                    end else if (chan_reg == CH_OUTPUT_CURRENT && aux_on_reg) begin
                        chan_next = CH_AUX;
                    end else if (round_reg == round_last) begin
                        state_next = SEQ_DONE;
                    end else begin
                        chan_next  = CH_VIN;
                        round_next = round_reg + 8'h01;
                    end
                end
            end
            SEQ_DONE: begin
                // continuous mode returns to idle and restarts while run is set
                state_next = SEQ_IDLE;
            end
            default: begin
                state_next = SEQ_IDLE;
            end
        endcase
        // clearing the run bit abandons a cycle in progress
        if (!run_reg && (state_reg == SEQ_REQ || state_reg == SEQ_WAIT)) begin
            state_next = SEQ_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // read port and alert
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next   = rdata_reg;
        unknown_next = 1'b0;
        if (reg_rd) begin
            // upper nibble of peak reads zero
            if (reg_cmd == CMD_PEAK_AUX) begin
                rdata_next = {4'h0, peak_reg};
            // run control upper bits read zero
            end else if (reg_cmd == CMD_RUN_CTRL) begin
                rdata_next = {15'h0000, run_reg};
            end else if (reg_cmd == CMD_SAMPLE_CFG) begin
                rdata_next = {8'h00, cfg_reg};
            end else if (reg_cmd == CMD_ALERT_EN) begin
                rdata_next = alert_en_reg;
            end else begin
                rdata_next   = 16'h0000;
                unknown_next = 1'b1;
            end
        end
        // alert follows enabled flags; switch health, overcurrent, overvoltage
        alert_next = (switch_health_bad_flag && alert_en_reg[HEALTH_EN_BIT])
                   || (overcurrent_fault_flag && alert_en_reg[OC_EN_BIT])
                   || (input_overvoltage_fault_flag && alert_en_reg[OV_EN_BIT]);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg    <= SEQ_IDLE;
            chan_reg     <= CH_VIN;
            round_reg    <= 8'h00;
            avg_log_reg  <= 3'h0;
            aux_on_reg   <= 1'b0;
            run_reg      <= RUN_RESET;
            cfg_reg      <= CFG_RESET;
            alert_en_reg <= ALERT_EN_RESET;
            peak_reg     <= PEAK_RESET;
            rdata_reg    <= 16'h0000;
            rack_reg     <= 1'b0;
            unknown_reg  <= 1'b0;
            alert_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            chan_reg     <= chan_next;
            round_reg    <= round_next;
            avg_log_reg  <= avg_log_next;
            aux_on_reg   <= aux_on_next;
            run_reg      <= run_next;
            cfg_reg      <= cfg_next;
            alert_en_reg <= alert_en_next;
            peak_reg     <= peak_next;
            rdata_reg    <= rdata_next;
            rack_reg     <= reg_rd;
            unknown_reg  <= unknown_next;
            alert_reg    <= alert_next;
        end
    end

    // ------------------------------------------------------------------
    // averaging accumulators
    // ------------------------------------------------------------------
    assign vin_link.clear         = (state_reg == SEQ_IDLE);
    assign vin_link.sample_valid  = sample_done && (chan_reg == CH_VIN);
    assign vin_link.sample        = conv_result;
    assign vin_link.avg_log       = avg_log_reg;
    assign vin_link.publish       = (state_reg == SEQ_DONE);
    assign output_current_link.clear        = (state_reg == SEQ_IDLE);
    assign output_current_link.sample_valid = sample_done && (chan_reg == CH_OUTPUT_CURRENT);
    assign output_current_link.sample       = conv_result;
    assign output_current_link.avg_log      = avg_log_reg;
    assign output_current_link.publish      = (state_reg == SEQ_DONE);

    avg_accum #(.DATA_W(DATA_W), .MAX_LOG(7)) u_vin_avg (
        .core_clk (core_clk),
        .rst      (rst),
        .link     (vin_link.acc)
    );

    avg_accum #(.DATA_W(DATA_W), .MAX_LOG(7)) u_output_current_avg (
        .core_clk (core_clk),
        .rst      (rst),
        .link     (output_current_link.acc)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata             = rdata_reg;
    assign reg_rack              = rack_reg;
    assign reg_unknown           = unknown_reg;
    assign conv_start            = (state_reg == SEQ_REQ);
    assign conv_channel          = chan_reg;
    assign current_sense_range   = cfg_reg[RANGE_LSB +: 2];
    assign vin_avg               = vin_link.result;
    assign output_current_avg              = output_current_link.result;
    // results land one cycle after the publish state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            results_valid <= 1'b0;
        end else begin
            results_valid <= (state_reg == SEQ_DONE);
        end
    end
    assign alert                 = alert_reg;
    // open-drain alert pin pulls low while alert and function is alert
    assign general_output_one_o  = 1'b0;
    assign general_output_one_oe = alert_reg
        && (alert_en_reg[OUT1_FN_LSB +: 2] == OUT1_FN_ALERT);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_peak_read_zero: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_cmd == CMD_PEAK_AUX |=> reg_rack && reg_rdata == {4'h0, $past(peak_reg)})
        else $error("peak read wrong");
    a_peak_clear: assert property (@(posedge core_clk) disable iff (rst)
        peak_clear && !aux_valid |=> peak_reg == PEAK_RESET)
        else $error("peak not cleared");
    a_run_stop: assert property (@(posedge core_clk) disable iff (rst)
        !run_reg && !wr_run && (state_reg == SEQ_WAIT)
        |=> state_reg == SEQ_IDLE ##1 state_reg == SEQ_IDLE)
        else $error("sequencer kept running");
    a_single_clear: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == SEQ_DONE && !cfg_reg[MODE_BIT] && !wr_run |=> !run_reg)
        else $error("single-shot run not cleared");
    a_cont_keep: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == SEQ_DONE && run_reg && cfg_reg[MODE_BIT] && !wr_run
        |=> run_reg ##1 state_reg == SEQ_REQ)
        else $error("continuous mode stopped");
    a_run_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_cmd == CMD_RUN_CTRL |=> reg_rdata[15:1] == 15'h0000)
        else $error("run reserved bits set");
    a_aux_gate: assert property (@(posedge core_clk) disable iff (rst)
        conv_start && conv_channel == CH_AUX |-> aux_on_reg)
        else $error("aux sampled while disabled");
    a_avg_rounds: assert property (@(posedge core_clk) disable iff (rst)
        state_reg == SEQ_DONE |-> round_reg == round_last && $past(state_reg) == SEQ_WAIT)
        else $error("averaging count wrong");
    a_reset_values: assert property (@(posedge core_clk)
        $past(rst) && !rst |-> cfg_reg == CFG_RESET && alert_en_reg == ALERT_EN_RESET && run_reg)
        else $error("reset values wrong");
    a_peak_rise: assert property (@(posedge core_clk) disable iff (rst)
        aux_valid && !peak_clear && conv_result <= peak_reg |=> $stable(peak_reg))
        else $error("peak lowered");
    a_alert_oc: assert property (@(posedge core_clk) disable iff (rst)
        overcurrent_fault_flag && alert_en_reg[OC_EN_BIT] |=> alert)
        else $error("overcurrent alert missing");
    a_alert_quiet: assert property (@(posedge core_clk) disable iff (rst)
        !switch_health_bad_flag && !overcurrent_fault_flag
        && !input_overvoltage_fault_flag |=> !alert && !general_output_one_oe)
        else $error("alert without flag");

endmodule // pmon_sequencer

// ---- pmon_pkg.sv ----
// constants for the power monitor sampling sequencer: command codes,
// reset values, field positions and state encodings.
// assumes a command port addressed by the 8-bit register command code.
package pmon_pkg;

    // ------------------------------------------------------------------
    // register command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_PEAK_AUX    = 8'hD2;
    localparam logic [7:0] CMD_RUN_CTRL    = 8'hD3;
    localparam logic [7:0] CMD_SAMPLE_CFG  = 8'hD4;
    localparam logic [7:0] CMD_ALERT_EN    = 8'hD5;

    // ------------------------------------------------------------------
    // reset values and clear pattern
    // ------------------------------------------------------------------
    localparam logic [11:0] PEAK_RESET       = 12'h000;
    localparam logic [15:0] PEAK_CLEAR_VALUE = 16'h0000;
    localparam logic        RUN_RESET        = 1'b1;
    localparam logic [7:0]  SAMPLE_CFG_RESET = 8'h8F;
    localparam logic [15:0] ALERT_EN_RESET   = 16'h8000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          PEAK_W          = 12;
    localparam int          RUN_BIT         = 0;
    localparam int          MODE_BIT        = 7;
    localparam int          AUX_BIT         = 6;
    localparam int          RANGE_LSB       = 3;
    localparam int          AVG_LSB         = 0;
    localparam int          AVG_W           = 3;
    localparam logic [7:0]  CFG_RSVD_MASK   = 8'h20;
    localparam logic [7:0]  CFG_RANGE_MASK  = 8'h18;
    localparam int          HEALTH_EN_BIT   = 15;
    localparam int          OC_EN_BIT       = 14;
    localparam int          OV_EN_BIT       = 13;
    localparam int          OUT1_FN_LSB     = 1;
    localparam logic [1:0]  OUT1_FN_ALERT   = 2'b00;
    localparam logic [1:0]  RANGE_RSVD_LO   = 2'b00;
    localparam logic [1:0]  RANGE_RSVD_HI   = 2'b11;

    // ------------------------------------------------------------------
    // sequencer states and converter channels
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_REQ  = 2'b01,
        SEQ_WAIT = 2'b10,
        SEQ_DONE = 2'b11
    } seq_state_e;

    typedef enum logic [1:0] {
        CH_VIN  = 2'b00,
        CH_OUTPUT_CURRENT = 2'b01,
        CH_AUX  = 2'b10
    } adc_chan_e;

endpackage

// ---- avg_link_if.sv ----
// link between the sequencer and one averaging accumulator.
// assumes both ends share core_clk.
`timescale 1ns/1ns
interface avg_link_if #(parameter int DATA_W = 12);
    logic              clear;
    logic              sample_valid;
    logic [DATA_W-1:0] sample;
    logic [2:0]        avg_log;
    logic              publish;
    logic [DATA_W-1:0] result;

    modport ctrl (output clear, sample_valid, sample, avg_log, publish, input result);
    modport acc  (input clear, sample_valid, sample, avg_log, publish, output result);
endinterface

// ---- avg_accum.sv ----
// sample accumulator that averages a power-of-two number of samples.
// assumes the controller clears before the first sample and publishes
// at least one cycle after the last.
`timescale 1ns/1ns
module avg_accum
    import pmon_pkg::*;
#(
    parameter int DATA_W  = 12,
    parameter int MAX_LOG = 7
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // controller side
    avg_link_if.acc  link
);
    localparam int ACC_W = DATA_W + MAX_LOG;

    // ------------------------------------------------------------------
    // checks and state
    // ------------------------------------------------------------------
    if (MAX_LOG < 7 || DATA_W < 1) begin : g_bad_params
        $error("avg_accum needs MAX_LOG >= 7 and DATA_W >= 1");
    end

    logic [ACC_W-1:0]  sum_reg;
    logic [ACC_W-1:0]  sum_next;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] result_next;
    logic [ACC_W-1:0]  sum_base;

    // sum grows by one sample per valid; shift divides by the count
    always_comb begin
        sum_base    = link.clear ? '0 : sum_reg;
        sum_next    = sum_base;
        result_next = result_reg;
        if (link.sample_valid) begin
            sum_next = sum_base + ACC_W'(link.sample);
        end
        if (link.publish) begin
            result_next = DATA_W'(sum_reg >> link.avg_log);
        end
    end

    // registers only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sum_reg    <= '0;
            result_reg <= '0;
        end else begin
            sum_reg    <= sum_next;
            result_reg <= result_next;
        end
    end

    assign link.result = result_reg;

endmodule // avg_accum

// ---- conv_model.sv ----
// converter front end model: answers each start after 1 to 4 cycles.
// assumes starts come on core_clk and the bench supplies the results.
`timescale 1ns/1ns
module conv_model (
    // clock
    input  wire logic        core_clk,
    // converter link
    input  wire logic        conv_start,
    input  wire logic [11:0] next_val,
    input  wire logic [1:0]  lag,
    output logic             conv_done = 1'b0,
    output logic      [11:0] conv_result = 12'hA5A
);
    int wait_cnt = -1;

    // result is valid only with done; between answers it flips every cycle
    always @(posedge core_clk) begin
        conv_done   <= 1'b0;
        conv_result <= ~conv_result;
        if (conv_start) wait_cnt = lag;
        if (wait_cnt == 0) begin
            conv_done   <= 1'b1;
            conv_result <= next_val;
        end
        if (wait_cnt >= 0) wait_cnt--;
    end
endmodule // conv_model

// ---- power_monitor_sampling_control_tb.sv ----
// self-checking bench for the sampling sequencer, with a converter model.
// assumes the command port contract: one-cycle strobes, read answer after one cycle.
`timescale 1ns/1ns
module power_monitor_sampling_control_tb
    import pmon_pkg::*;
();
    logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, alert_chk = 0, exp_alert = 0;
    logic [7:0]  reg_cmd = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, en = 16'h8000, rdv;
    logic [2:0]  flags = 3'b000;
    logic [1:0]  lag = 2'b00, conv_channel, sense_rng;
    logic [11:0] next_val = 12'h000, conv_result, vin_avg, output_current_avg;
    logic [31:0] rnd = 32'hFCDF7074;
    logic [15:0] reg_rdata;
    logic        reg_rack, reg_unknown, conv_start, conv_done, results_valid, alert, g_o, g_oe;
    int          bad_count = 0, checks_done = 0, vsum = 0, isum = 0, peak = 0, avg = 0, nres = 0, n;
    logic [15:0] en_tab [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h0000, 16'hE002, 16'hE000};

    pmon_sequencer uut (.core_clk(core_clk), .rst(rst), .reg_cmd(reg_cmd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
        .reg_unknown(reg_unknown), .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_done(conv_done), .conv_result(conv_result), .current_sense_range(sense_rng),
        .vin_avg(vin_avg), .output_current_avg(output_current_avg), .results_valid(results_valid),
        .switch_health_bad_flag(flags[2]), .overcurrent_fault_flag(flags[1]),
        .input_overvoltage_fault_flag(flags[0]), .alert(alert),
        .general_output_one_o(g_o), .general_output_one_oe(g_oe));
    conv_model partner (.core_clk(core_clk), .conv_start(conv_start), .next_val(next_val),
        .lag(lag), .conv_done(conv_done), .conv_result(conv_result));

    always #10 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // random results and answer delays for the converter model
    always @(posedge core_clk) begin
        rnd      <= lfsr(rnd);
        next_val <= rnd[11:0];
        lag      <= rnd[13:12];
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_cmd   <= c;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic get(input logic [7:0] c, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd  <= 1'b1;
        reg_cmd <= c;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
        if (exp !== 16'hFFFF || c == CMD_ALERT_EN) check(rdv, exp);
        check({reg_rack, reg_unknown}, {1'b1, 1'(c < CMD_PEAK_AUX || c > CMD_ALERT_EN)});
    endtask

    // reference model: sums per channel, peak of aux, alert one cycle behind flags
    always @(posedge core_clk) begin
        if (!rst && conv_done && conv_channel == 2'h0) vsum += conv_result;
        if (!rst && conv_done && conv_channel == 2'h1) isum += conv_result;
        if (!rst && conv_done && conv_channel == 2'h2 && conv_result > peak) peak = conv_result;
        if (results_valid) begin
            check({4'h0, vin_avg}, 16'(vsum >> avg));
            check({4'h0, output_current_avg}, 16'(isum >> avg));
            vsum = 0;
            isum = 0;
            nres++;
        end
        if (alert_chk) begin
            check({15'h0, alert}, {15'h0, exp_alert});
            check({g_o, g_oe}, {1'b0, exp_alert && en[2:1] == 2'b00});
        end
        exp_alert = |(flags & en[15:13]);
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        get(CMD_RUN_CTRL, 16'h0001);
        get(CMD_SAMPLE_CFG, 16'h008F);
        get(CMD_ALERT_EN, 16'h8000);
        get(8'hD6, 16'h0000);
        check({14'h0, sense_rng}, 16'h0001);
        wr(CMD_RUN_CTRL, 16'hFFFE);
        get(CMD_RUN_CTRL, 16'h0000);
        wr(CMD_SAMPLE_CFG, 16'hFFFF);
        get(CMD_SAMPLE_CFG, 16'h00DF);
        $display("test registers done");
        // continuous, averaging two, host stops it
        wr(CMD_SAMPLE_CFG, 16'h0089);
        {vsum, isum, nres, avg} = {32'd0, 32'd0, 32'd0, 32'd1};
        wr(CMD_RUN_CTRL, 16'h0001);
        for (n = 0; n < 2000 && nres < 3; n++) @(posedge core_clk);
        check(16'(nres), 16'h0003);
        get(CMD_RUN_CTRL, 16'h0001);
        wr(CMD_RUN_CTRL, 16'h0000);
        $display("test continuous done");
        // single shot with aux, averaging four, range 50 mV
        repeat (8) @(posedge core_clk);
        wr(CMD_PEAK_AUX, 16'h0000);
        {vsum, isum, nres, avg, peak} = {32'd0, 32'd0, 32'd0, 32'd2, 32'd0};
        wr(CMD_SAMPLE_CFG, 16'h0052);
        #1;
        check({14'h0, sense_rng}, 16'h0002);
        wr(CMD_RUN_CTRL, 16'h0001);
        for (n = 0; n < 300 && rdv !== 16'h0000; n++) get(CMD_RUN_CTRL, 16'hFFFF);
        check(rdv, 16'h0000);
        repeat (6) @(posedge core_clk);
        check(16'(nres), 16'h0001);
        get(CMD_PEAK_AUX, 16'(peak));
        wr(CMD_PEAK_AUX, 16'h0001);
        get(CMD_PEAK_AUX, 16'(peak));
        wr(CMD_PEAK_AUX, 16'h0000);
        get(CMD_PEAK_AUX, 16'h0000);
        // single shot without averaging, aux off, range 25 mV
        {vsum, isum, nres, avg} = {32'd0, 32'd0, 32'd0, 32'd0};
        wr(CMD_SAMPLE_CFG, 16'h0008);
        wr(CMD_RUN_CTRL, 16'h0001);
        repeat (40) @(posedge core_clk);
        check(16'(nres), 16'h0001);
        get(CMD_RUN_CTRL, 16'h0000);
        $display("test single shot done");
        // each enable pattern against random fault flags
        foreach (en_tab[i]) begin
            wr(CMD_ALERT_EN, en_tab[i]);
            en = en_tab[i];
            get(CMD_ALERT_EN, en);
            repeat (2) @(posedge core_clk);
            alert_chk = 1'b1;
            repeat (30) begin
                @(posedge core_clk);
                flags <= rnd[18:16];
            end
            alert_chk = 1'b0;
        end
        $display("test alert done");
        print_verdict();
    end
endmodule // power_monitor_sampling_control_tb
